// [hw/regulator_group_enable_control.sv]
// Operation
// - Soft-start strap sampled once at power-up, default for all regulators.
// - Soft-start of regulators five to eight writable only after power-up.
// - Primary switching rate of regulators one to five fixed by strap.
// - Primary switching clock issued in four offset phases.
// - Secondary switching rate writable any time after power-up.
// - Summary fault register shows which regulator detects a fault.
// - Per-channel fault register records the kind of fault.
// - Normal mode acts on each command as soon as received.
// - Validated mode acts only on a command confirmed by its second copy.
// - Groups: boost; regulators two-four; five-seven; eight.
// - Fifth group holds regulator five only under sequencing option one.
// - Group on/off switches all its regulators together, except regulator five under option one.
// - Gate drive on unless lockout, pin off, global off or device fault.
// - Boost output needs gate drive, group-one on, no fault.
// - Regulators two-four need gate drive, group on and no group fault.
// - Regulator five also needs fifth group on and fault-free when option one.
// - Boost isolation switch ramps on gradually.
// - Discharge switch enabled for as long as a regulator is off.
// - Regulators two to five scale +17.5 % to -20 % in 2.5 % steps.
// - Regulator one scales +-10 % in 2.5 % steps.
// - Regulator three fine scaling in 0.5 % steps down to 40 %.
// - Per channel: over/under voltage either shuts off or only flags.
// - Short circuit: only core group retries once after 10 ms.
// - Thermal shuts its group; on regulators two-four the whole device.
// - After supply good: latch straps, ramp core group, then host control.
module regulator_group_enable_control
    import regulator_group_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYCLES_DEF
) (
    input  wire logic                     sys_clk,               // 125 MHz clock
    input  wire logic                     sys_rst,               // Async reset, high
    input  wire pins_t                    pins,                  // Pin level inputs
    input  wire logic                     validated_mode,        // Double-send mode
    input  wire logic                     cmd_valid,             // Command strobe
    input  wire cmd_t                     cmd,                   // Decoded command
    output logic                          rd_valid,              // Read answer strobe
    output logic [DATA_W-1:0]             rd_data,               // Read answer data
    output logic                          cmd_reject,            // Command dropped
    output logic                          power_up_done,         // Sequence complete
    output logic                          gate_drive_supply,     // Gate drive enable
    output logic [NUM_REG-1:0]            reg_enable,            // Regulator enables
    output logic [NUM_REG-1:0]            discharge_enable,      // Discharge switches
    output logic [DATA_W-1:0]             switched_boost_output, // Isolation gate level
    output logic [NUM_PHASE-1:0]          primary_switch_rate,   // Phase strobes
    output logic                          secondary_switch_rate, // Secondary strobe
    output ss_arr_t                       soft_start_code,       // Soft-start settings
    output scale_arr_t                    voltage_scaling_setting, // Coarse scaling
    output logic [FINE_W-1:0]             fine_scale,            // Fine scaling
    output logic [NUM_REG-1:0]            fault_summary,         // Summary faults
    output fault_arr_t                    fault_record,          // Channel faults
    output logic                          core_soft_start_restart // Retry restart
);

    // ============================================================
    // State
    typedef struct packed {
        pins_t                       pin1;
        pins_t                       pin2;
        seq_state_t                  seq;
        logic [RATE_W-1:0]           strap_rate;
        logic [NUM_GROUP-1:0]        grp_on;
        logic [NUM_GROUP-1:0]        grp_fault;
        logic                        global_off;
        logic                        dev_fault;
        logic                        seq_opt1;
        logic                        retry_pend;
        logic                        retry_used;
        logic [RETRY_W-1:0]          retry_cnt;
        fault_arr_t                  rec;
        logic [NUM_REG-1:0]          resp_shut;
        ss_arr_t                     ss;
        scale_arr_t                  scale;
        logic [FINE_W-1:0]           fine;
        logic [DATA_W-1:0]           sec_period;
        logic [DATA_W-1:0]           sec_cnt;
        logic [DATA_W-1:0]           pri_cnt;
        logic [NUM_PHASE-1:0]        phase;
        logic                        sec_pulse;
        logic [DATA_W-1:0]           ramp_cnt;
        logic [DATA_W-1:0]           iso;
        logic                        pend;
        cmd_t                        first;
        logic [NUM_REG-1:0]          reg_en;
        logic [NUM_REG-1:0]          dis_en;
        logic                        vg_en;
        logic [NUM_REG-1:0]          summary;
        logic                        rd_valid;
        logic [DATA_W-1:0]           rd_data;
        logic                        reject;
        logic                        done;
        logic                        ss_restart;
    } state_t;

    state_t s;
    state_t next_s;

    // ============================================================
    // Next state
    always_comb begin
        logic                 act;
        logic                 off_cause;
        logic                 live;
        logic [NUM_GROUP-1:0] grp_live;
        logic [DATA_W-1:0]    period;
        fault_t               f;
        int                   g;
        int                   ch;
        act       = 1'b0;
        off_cause = 1'b0;
        live      = 1'b0;
        grp_live  = '0;
        period    = '0;
        f         = '0;
        g         = 0;
        ch        = int'(cmd.chan);

        next_s            = s;
        next_s.pin1       = pins;
        next_s.pin2       = s.pin1;
        next_s.rd_valid   = 1'b0;
        next_s.reject     = 1'b0;
        next_s.ss_restart = 1'b0;

        // Command acceptance
        if (!validated_mode) begin
            next_s.pend = 1'b0;
            act = cmd_valid;
        end else if (cmd_valid) begin
            if (!s.pend) begin
                next_s.pend  = 1'b1;
                next_s.first = cmd;
            end else begin
                next_s.pend = 1'b0;
                if (cmd == s.first) begin
                    act = 1'b1;
                end else begin
                    next_s.reject = 1'b1;
                end
            end
        end

        if (act) begin
            case (cmd.target)
                T_GROUP_ON: begin
                    if (s.done && ch < NUM_GROUP) begin
                        next_s.grp_on[ch] = 1'b1;
                    end
                end
                T_GROUP_OFF: begin
                    if (ch < NUM_GROUP) begin
                        next_s.grp_on[ch] = 1'b0;
                    end
                end
                T_GLOBAL_OFF: begin
                    next_s.global_off = 1'b1;
                end
                T_SOFT_START: begin
                    if (s.done && ch >= REG_SS_FIRST) begin
                        next_s.ss[ch] = cmd.data[SS_W-1:0];
                    end else begin
                        next_s.reject = 1'b1;
                    end
                end
                T_SEC_RATE: begin
                    if (s.done) begin
                        next_s.sec_period = (cmd.data < SEC_PERIOD_MIN) ? SEC_PERIOD_MIN
                                                                         : cmd.data;
                    end else begin
                        next_s.reject = 1'b1;
                    end
                end
                T_SCALE: begin
                    next_s.scale[ch] = clamp_scale(cmd.data, ch);
                end
                T_FINE_SCALE: begin
                    next_s.fine = (cmd.data[FINE_W-1:0] > FINE_MAX || cmd.data[DATA_W-1])
                                ? FINE_MAX : cmd.data[FINE_W-1:0];
                end
                T_FAULT_RESP: begin
                    next_s.resp_shut[ch] = cmd.data[0];
                end
                T_FAULT_CLEAR: begin
                    next_s.rec[ch] = '0;
                    if (!s.retry_pend) begin
                        next_s.grp_fault[reg_group(ch)] = 1'b0;
                    end
                end
                T_SEQ_OPTION: begin
                    next_s.seq_opt1 = cmd.data[0];
                end
                T_READ_SUMMARY: begin
                    next_s.rd_valid = 1'b1;
                    next_s.rd_data  = s.summary;
                end
                T_READ_CHANNEL: begin
                    next_s.rd_valid = 1'b1;
                    next_s.rd_data  = DATA_W'(s.rec[ch]);
                end
                default: begin
                    next_s.reject = 1'b1;
                end
            endcase
        end

        if (s.retry_pend) begin
            if (s.retry_cnt == RETRY_W'(RETRY_CYCLES - 1)) begin
                next_s.retry_pend        = 1'b0;
                next_s.retry_used        = 1'b1;
                next_s.grp_fault[G_CORE] = 1'b0;
                next_s.ss_restart        = 1'b1;
            end else begin
                next_s.retry_cnt = s.retry_cnt + 1'b1;
            end
        end

        // Fault capture, set wins over clear
        for (int i = 0; i < NUM_REG; i++) begin
            f = s.pin2.faults[i];
            g = reg_group(i);
            if (s.reg_en[i]) begin
                next_s.rec[i] = next_s.rec[i] | f;
                if (f.thermal) begin
                    next_s.grp_fault[g] = 1'b1;
                    if (g == G_CORE) begin
                        next_s.dev_fault = 1'b1;
                    end
                end
                if ((f.ov || f.uv) && s.resp_shut[i]) begin
                    next_s.grp_fault[g] = 1'b1;
                end
                if (f.short_circuit) begin
                    next_s.grp_fault[g] = 1'b1;
                    if (g == G_CORE && !s.retry_used && !s.retry_pend) begin
                        next_s.retry_pend = 1'b1;
                        next_s.retry_cnt  = '0;
                    end
                end
            end
        end

        off_cause = s.pin2.uvlo || !s.pin2.hard_power_switch_pin
                 || next_s.global_off || next_s.dev_fault;

        case (s.seq)
            ST_POR: begin
                if (s.pin2.vddi_ok) begin
                    next_s.seq = ST_LATCH;
                end
            end
            ST_LATCH: begin
                next_s.strap_rate = s.pin2.rate_strap_pin;
                next_s.ss         = {NUM_REG{s.pin2.soft_start_strap}};
                next_s.grp_on     = NUM_GROUP'(1) << G_CORE;
                next_s.grp_fault  = '0;
                next_s.retry_used = 1'b0;
                next_s.seq        = ST_CORE_RAMP;
            end
            ST_CORE_RAMP: begin
                if (s.pin2.core_pgood) begin
                    next_s.seq = ST_RUN;
                end
            end
            ST_RUN: begin
                next_s.seq = ST_RUN;
            end
            ST_OFF: begin
                next_s.grp_on = '0;
                if (!s.pin2.hard_power_switch_pin) begin
                    next_s.global_off = 1'b0;
                    next_s.dev_fault  = 1'b0;
                end else if (!off_cause) begin
                    next_s.seq = ST_POR;
                end
            end
            default: begin
                next_s.seq = ST_POR;
            end
        endcase
        if (off_cause && s.seq != ST_OFF) begin
            next_s.seq    = ST_OFF;
            next_s.grp_on = '0;
        end
        next_s.done  = (next_s.seq == ST_RUN);
        next_s.vg_en = (next_s.seq != ST_OFF);

        live = (s.seq == ST_CORE_RAMP || s.seq == ST_RUN) && s.pin2.gate_drive_ok
            && next_s.vg_en;
        for (int k = 0; k < NUM_GROUP; k++) begin
            grp_live[k] = live && next_s.grp_on[k] && !next_s.grp_fault[k];
        end
        for (int i = 0; i < NUM_REG; i++) begin
            next_s.reg_en[i] = grp_live[reg_group(i)];
        end
        if (next_s.seq_opt1 && !grp_live[G_ALT]) begin
            next_s.reg_en[REG_AUX] = 1'b0;
        end
        next_s.dis_en = ~next_s.reg_en;

        for (int i = 0; i < NUM_REG; i++) begin
            next_s.summary[i] = |next_s.rec[i];
        end

        if (!next_s.reg_en[REG_BOOST]) begin
            next_s.iso      = '0;
            next_s.ramp_cnt = '0;
        end else if (s.iso != ISO_FULL) begin
            if (s.ramp_cnt == DATA_W'(RAMP_STEP_CYCLES - 1)) begin
                next_s.ramp_cnt = '0;
                next_s.iso      = s.iso + 1'b1;
            end else begin
                next_s.ramp_cnt = s.ramp_cnt + 1'b1;
            end
        end

        period         = rate_period(s.strap_rate);
        next_s.pri_cnt = (s.pri_cnt >= period - 1'b1) ? '0 : s.pri_cnt + 1'b1;
        for (int k = 0; k < NUM_PHASE; k++) begin
            next_s.phase[k] = live && (s.pri_cnt == phase_offset(period, k));
        end
        next_s.sec_cnt   = (s.sec_cnt >= s.sec_period - 1'b1) ? '0 : s.sec_cnt + 1'b1;
        next_s.sec_pulse = live && (s.sec_cnt == '0);
    end

    // ============================================================
    // Registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s            <= '0;
            s.sec_period <= SEC_PERIOD_DEF;
            s.dis_en     <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs
    assign rd_valid                = s.rd_valid;
    assign rd_data                 = s.rd_data;
    assign cmd_reject              = s.reject;
    assign power_up_done           = s.done;
    assign gate_drive_supply       = s.vg_en;
    assign reg_enable              = s.reg_en;
    assign discharge_enable        = s.dis_en;
    assign switched_boost_output   = s.iso;
    assign primary_switch_rate     = s.phase;
    assign secondary_switch_rate   = s.sec_pulse;
    assign soft_start_code         = s.ss;
    assign voltage_scaling_setting = s.scale;
    assign fine_scale              = s.fine;
    assign fault_summary           = s.summary;
    assign fault_record            = s.rec;
    assign core_soft_start_restart = s.ss_restart;

endmodule

// [hw/regulator_group_pkg.sv]
package regulator_group_pkg;

    // ============================================================
    // Sizes and indices
    localparam int NUM_REG   = 8;
    localparam int NUM_GROUP = 5;
    localparam int NUM_PHASE = 4;
    localparam int SS_W      = 3;
    localparam int RATE_W    = 2;
    localparam int SCALE_W   = 4;
    localparam int FINE_W    = 7;
    localparam int DATA_W    = 8;
    localparam int CHAN_W    = 3;
    localparam int RETRY_W   = 21;

    localparam int G_BOOST = 0;
    localparam int G_CORE  = 1;
    localparam int G_AUX   = 2;
    localparam int G_LED   = 3;
    localparam int G_ALT   = 4;

    localparam int REG_BOOST      = 0;
    localparam int REG_CORE_FIRST = 1;
    localparam int REG_CORE_LAST  = 3;
    localparam int REG_AUX        = 4;
    localparam int REG_AUX_LAST   = 6;
    localparam int REG_SS_FIRST   = 4;

    // ============================================================
    // Scaling limits in steps (2.5 % coarse, 0.5 % fine)
    localparam int SCALE_WIDE_HI   = 7;
    localparam int SCALE_WIDE_LO   = -8;
    localparam int SCALE_NARROW_HI = 4;
    localparam int SCALE_NARROW_LO = -4;
    localparam logic [FINE_W-1:0] FINE_MAX = 7'h78;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int RETRY_TIME_MS    = 10;
    localparam int RETRY_CYCLES_DEF = RETRY_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RAMP_STEP_NS     = 1000;
    localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE_DEG        = 80;
    localparam int DEG_FULL         = 360;

    localparam logic [DATA_W-1:0] ISO_FULL       = 8'hFF;
    localparam logic [DATA_W-1:0] SEC_PERIOD_DEF = 8'h7D;
    localparam logic [DATA_W-1:0] SEC_PERIOD_MIN = 8'h02;
    localparam logic [DATA_W-1:0] RATE_P0        = 8'h7D;
    localparam logic [DATA_W-1:0] RATE_P1        = 8'h64;
    localparam logic [DATA_W-1:0] RATE_P2        = 8'h53;
    localparam logic [DATA_W-1:0] RATE_P3        = 8'h3F;

    // ============================================================
    // Types
    typedef struct packed {
        logic ov;
        logic uv;
        logic short_circuit;
        logic thermal;
    } fault_t;

    typedef fault_t [NUM_REG-1:0]              fault_arr_t;
    typedef logic [NUM_REG-1:0][SS_W-1:0]      ss_arr_t;
    typedef logic [NUM_REG-1:0][SCALE_W-1:0]   scale_arr_t;

    typedef struct packed {
        fault_arr_t        faults;
        logic [SS_W-1:0]   soft_start_strap;
        logic [RATE_W-1:0] rate_strap_pin;
        logic              hard_power_switch_pin;
        logic              uvlo;
        logic              vddi_ok;
        logic              gate_drive_ok;
        logic              core_pgood;
    } pins_t;

    typedef enum logic [3:0] {
        T_GROUP_ON, T_GROUP_OFF, T_GLOBAL_OFF, T_SOFT_START, T_SEC_RATE,
        T_SCALE, T_FINE_SCALE, T_FAULT_RESP, T_FAULT_CLEAR, T_SEQ_OPTION,
        T_READ_SUMMARY, T_READ_CHANNEL
    } cmd_target_t;

    typedef struct packed {
        cmd_target_t       target;
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } cmd_t;

    typedef enum logic [2:0] {
        ST_POR, ST_LATCH, ST_CORE_RAMP, ST_RUN, ST_OFF
    } seq_state_t;

    // ============================================================
    // Decoders
    function automatic int reg_group(input int i);
        if (i == REG_BOOST) return G_BOOST;
        if (i <= REG_CORE_LAST) return G_CORE;
        if (i <= REG_AUX_LAST) return G_AUX;
        return G_LED;
    endfunction

    function automatic logic [SCALE_W-1:0] clamp_scale(input logic [DATA_W-1:0] d,
                                                       input int ch);
        int v;
        int lo;
        int hi;
        v  = int'($signed(d));
        lo = (ch >= REG_CORE_FIRST && ch <= REG_AUX) ? SCALE_WIDE_LO : SCALE_NARROW_LO;
        hi = (ch >= REG_CORE_FIRST && ch <= REG_AUX) ? SCALE_WIDE_HI : SCALE_NARROW_HI;
        if (v > hi) v = hi;
        else if (v < lo) v = lo;
        return v[SCALE_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] rate_period(input logic [RATE_W-1:0] r);
        case (r)
            2'h0:    return RATE_P0;
            2'h1:    return RATE_P1;
            2'h2:    return RATE_P2;
            default: return RATE_P3;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] phase_offset(input logic [DATA_W-1:0] per,
                                                       input int k);
        int t;
        t = int'(per) * PHASE_DEG * k / DEG_FULL;
        return t[DATA_W-1:0];
    endfunction

endpackage

// [verification/regulator_group_properties.sv]
module regulator_group_props
    import regulator_group_pkg::*;
(
    input wire logic              sys_clk,               // Clock
    input wire logic              sys_rst,               // Reset
    input wire pins_t             pins,                  // Pins
    input wire logic              validated_mode,        // Mode
    input wire logic              cmd_valid,             // Strobe
    input wire cmd_t              cmd,                   // Command
    input wire logic              rd_valid,              // Read strobe
    input wire logic              cmd_reject,            // Refusal
    input wire logic              power_up_done,         // Done
    input wire logic              gate_drive_supply,     // Gate drive
    input wire logic [NUM_REG-1:0] reg_enable,           // Enables
    input wire logic [NUM_REG-1:0] discharge_enable,     // Discharge
    input wire logic [DATA_W-1:0] switched_boost_output, // Isolation gate
    input wire logic [NUM_PHASE-1:0] primary_switch_rate // Phases
);
    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    a_discharge_mirror: assert property (discharge_enable == ~reg_enable)
        else $error("discharge not inverse of enable");
    a_read_answer: assert property (
        cmd_valid && !validated_mode && cmd.target == T_READ_SUMMARY |=> rd_valid)
        else $error("no read answer");
    a_early_refuse: assert property (cmd_valid && !validated_mode && !power_up_done &&
        (cmd.target == T_SOFT_START || cmd.target == T_SEC_RATE) |=> cmd_reject)
        else $error("early write not refused");
    a_core_together: assert property (reg_enable[3:1] == 3'h0 || reg_enable[3:1] == 3'h7)
        else $error("core group split");
    a_gate_needed: assert property (|reg_enable |-> gate_drive_supply)
        else $error("regulator on without gate drive");
    a_boost_idle: assert property (
        !reg_enable[0] && !$past(reg_enable[0]) |-> switched_boost_output == 8'h00)
        else $error("boost output while off");
    a_ramp_step: assert property ($changed(switched_boost_output) &&
        switched_boost_output != 8'h00 |-> switched_boost_output == $past(switched_boost_output) + 8'h01)
        else $error("boost ramp jumped");
    a_phase_apart: assert property ($onehot0(primary_switch_rate))
        else $error("phases coincide");
    a_thermal_off: assert property (
        reg_enable[2] && pins.faults[2].thermal |-> ##[1:6] !gate_drive_supply)
        else $error("thermal did not stop device");
    cover property (rd_valid);
    cover property (cmd_reject);
    cover property ($rose(power_up_done));
endmodule
bind regulator_group_enable_control regulator_group_props u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins), .validated_mode(validated_mode),
    .cmd_valid(cmd_valid), .cmd(cmd), .rd_valid(rd_valid), .cmd_reject(cmd_reject),
    .power_up_done(power_up_done), .gate_drive_supply(gate_drive_supply),
    .reg_enable(reg_enable), .discharge_enable(discharge_enable),
    .switched_boost_output(switched_boost_output), .primary_switch_rate(primary_switch_rate));

// [verification/host_model.sv]
module host_model
    import regulator_group_pkg::*;
(
    input wire logic              sys_clk,        // Clock
    input wire logic              validated_mode, // Mode
    input wire logic              cmd_reject,     // Refusal
    input wire logic [DATA_W-1:0] rd_data,        // Read answer
    output cmd_t                  cmd,            // Command
    output logic                  cmd_valid       // Strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    task automatic send(input cmd_t c, input bit bad, output logic rej, output logic [7:0] rd);
        int n;
        n = validated_mode ? 2 : 1;
        for (int k = 0; k < n; k++) begin
            @(posedge sys_clk);
            cmd_valid <= 1'b1;
            cmd <= (k == 1 && bad) ? cmd_t'(c ^ 15'h0001) : c;
            @(posedge sys_clk);
            cmd_valid <= 1'b0;
            cmd <= cmd_t'(~c);
        end
        #1;
        rej = cmd_reject;
        rd = rd_data;
        @(posedge sys_clk);
    endtask
endmodule

// [verification/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import regulator_group_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, vmode = 1'b0, rej, cmd_valid, cmd_reject, done, gate;
    pins_t pins = '0;
    cmd_t cmd;
    logic [7:0] rd, rd_data, boost, en, dis;
    logic [6:0] fine;
    ss_arr_t ss;
    scale_arr_t sc;
    int fail_count = 0, n_checks = 0, cyc = 0;
    always #4 sys_clk = ~sys_clk;
    regulator_group_enable_control #(.RETRY_CYCLES(50)) dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .pins(pins), .validated_mode(vmode), .cmd_valid(cmd_valid),
        .cmd(cmd), .rd_valid(), .rd_data(rd_data), .cmd_reject(cmd_reject),
        .power_up_done(done), .gate_drive_supply(gate), .reg_enable(en),
        .discharge_enable(dis), .switched_boost_output(boost), .primary_switch_rate(),
        .secondary_switch_rate(), .soft_start_code(ss), .voltage_scaling_setting(sc),
        .fine_scale(fine), .fault_summary(), .fault_record(), .core_soft_start_restart());
    host_model host (.sys_clk(sys_clk), .validated_mode(vmode), .cmd_reject(cmd_reject),
        .rd_data(rd_data), .cmd(cmd), .cmd_valid(cmd_valid));
    // ============================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic go(cmd_target_t t, int ch, logic [7:0] d, bit bad = 0);
        host.send('{t, ch[2:0], d}, bad, rej, rd);
    endtask
    task automatic w(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ============================================================
    // Scenarios
    task automatic t_power_up();
        go(T_SOFT_START, 4, 8'h01);
        check(rej, 1'b1);
        go(T_SEC_RATE, 0, 8'h10);
        check(rej, 1'b1);
        pins.vddi_ok <= 1'b1;
        pins.core_pgood <= 1'b1;
        for (int i = 0; i < 200 && done !== 1'b1; i++) w(1);
        check(done, 1'b1);
        check(en, 8'h0E);
        check(dis, 8'hF1);
        for (int i = 0; i < NUM_REG; i++) check(ss[i], 3'h5);
    endtask
    task automatic t_boost();
        go(T_GROUP_ON, G_BOOST, 8'h00);
        w(3 * 125);
        check(en[0], 1'b1);
        check(boost > 8'h00 && boost < 8'h05, 1'b1);
        go(T_GROUP_OFF, G_BOOST, 8'h00);
        w(2);
        check(dis[0], 1'b1);
        check(boost, 8'h00);
    endtask
    task automatic t_scale();
        go(T_SCALE, 1, 8'h7F);
        go(T_SCALE, 4, 8'h80);
        go(T_SCALE, 0, 8'h80);
        go(T_SCALE, 7, 8'h7F);
        go(T_FINE_SCALE, 2, 8'hFF);
        go(T_SOFT_START, 4, 8'h03);
        go(T_GROUP_ON, G_AUX, 8'h00);
        go(T_SEQ_OPTION, 0, 8'h01);
        check(en[6:4], 3'h6);
        w(2);
        check(sc[1], 4'h7);
        check(sc[4], 4'h8);
        check(sc[0], 4'hC);
        check(sc[7], 4'h4);
        check(fine, 7'h78);
        check(ss[4], 3'h3);
    endtask
    task automatic t_validated();
        vmode <= 1'b1;
        w(1);
        go(T_SCALE, 2, 8'h02, 1);
        check(rej, 1'b1);
        w(2);
        check(sc[2], 4'h0);
        go(T_SCALE, 2, 8'h02);
        check(rej, 1'b0);
        w(2);
        check(sc[2], 4'h2);
        vmode <= 1'b0;
        w(1);
    endtask
    task automatic t_faults();
        go(T_FAULT_RESP, 2, 8'h00);
        pins.faults[2].uv <= 1'b1;
        w(6);
        check(en[3:1], 3'h7);
        go(T_READ_SUMMARY, 0, 8'h00);
        check(rd, 8'h04);
        go(T_READ_CHANNEL, 2, 8'h00);
        check(rd, 8'h04);
        pins.faults[2].thermal <= 1'b1;
        w(8);
        check(gate, 1'b0);
        check(en, 8'h00);
    endtask
    initial begin
        w(12);
        sys_rst <= 1'b0;
        pins.soft_start_strap <= 3'h5;
        pins.hard_power_switch_pin <= 1'b1;
        pins.gate_drive_ok <= 1'b1;
        w(1);
        t_power_up();
        t_boost();
        t_scale();
        t_validated();
        t_faults();
        report_and_stop();
    end
endmodule
